// [hw/pfp_defs.vh]
// Functional notes
// - high disable 0 makes a high window ending at top address; 1 removes it
// - high size field writable only while high disable is one
// - low disable 0 makes a low window starting at low base; 1 removes it
// - low size field writable only while low disable is one
// - open mode one: enabled windows are the protected areas
// - open mode zero: all protected except enabled windows
// - high window starts at 3F800, 3F000, 3E000 or 3C000 by size code
// - low window ends at 383FF, 387FF, 38FFF or 39FFF by size code
// - reset sequence loads config byte from nonvolatile 3FF0C before operation
// - after load, software may modify config within field write limits
`ifndef PFP_DEFS_VH
`define PFP_DEFS_VH

// ==========================================
// register map (apb byte addresses)
`define PFP_OFF_CONFIG 12'h000
`define PFP_OFF_STATUS 12'h004
`define PFP_OFF_CHECK 12'h008

// ==========================================
// config field positions
`define PFP_BIT_OPEN 7
`define PFP_BIT_HDIS 5
`define PFP_HS_HI 4
`define PFP_HS_LO 3
`define PFP_BIT_LDIS 2
`define PFP_LS_HI 1
`define PFP_LS_LO 0
`define PFP_CFG_WMASK 8'hA4
`define PFP_CFG_RESET 8'hFF

// ==========================================
// address map of the array
`define PFP_TOP_ADDR 18'h3FFFF
`define PFP_LOW_BASE 18'h38000
`define PFP_HI_START0 18'h3F800
`define PFP_HI_START1 18'h3F000
`define PFP_HI_START2 18'h3E000
`define PFP_HI_START3 18'h3C000
`define PFP_LO_END0 18'h383FF
`define PFP_LO_END1 18'h387FF
`define PFP_LO_END2 18'h38FFF
`define PFP_LO_END3 18'h39FFF
`define PFP_NV_CFG_ADDR 18'h3FF0C

`endif

// [hw/pfp_loader.v]
`include "pfp_defs.vh"

module pfp_loader (
    // clock and reset
    input wire ref_clk,
    input wire nrst,
    // nonvolatile read port
    output reg nv_req_r,
    output reg [17:0] nv_addr_r,
    input wire nv_ack,
    input wire [7:0] nv_rdata,
    // result
    output reg load_stb_r,
    output reg [7:0] load_data_r,
    output reg done_r
);

    localparam ST_IDLE = 2'b00;
    localparam ST_WAIT = 2'b01;
    localparam ST_DONE = 2'b10;

    reg [1:0] st_r;

    // ==========================================
    // one fetch of the config byte after reset release
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= ST_IDLE;
            nv_req_r <= 1'b0;
            nv_addr_r <= 18'h00000;
            load_stb_r <= 1'b0;
            load_data_r <= 8'h00;
            done_r <= 1'b0;
        end else begin
            load_stb_r <= 1'b0;
            case (st_r)
                ST_IDLE: begin
                    nv_req_r <= 1'b1;
                    nv_addr_r <= `PFP_NV_CFG_ADDR;
                    st_r <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (nv_ack) begin
                        nv_req_r <= 1'b0;
                        load_stb_r <= 1'b1;
                        load_data_r <= nv_rdata;
                        st_r <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    done_r <= 1'b1;
                end
                default: begin
                    st_r <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // pfp_loader

// [hw/pfp_range_check.v]
`include "pfp_defs.vh"

module pfp_range_check (
    // configuration
    input wire [7:0] cfg,
    // address under test
    input wire [17:0] addr,
    // result
    output wire prot
);

    reg [17:0] hi_start;
    reg [17:0] lo_end;
    wire in_hi;
    wire in_lo;
    wire hi_en;
    wire lo_en;

    // ==========================================
    // window bounds from size codes
    always @* begin
        case (cfg[`PFP_HS_HI:`PFP_HS_LO])
            2'h0: hi_start = `PFP_HI_START0;
            2'h1: hi_start = `PFP_HI_START1;
            2'h2: hi_start = `PFP_HI_START2;
            default: hi_start = `PFP_HI_START3;
        endcase
        case (cfg[`PFP_LS_HI:`PFP_LS_LO])
            2'h0: lo_end = `PFP_LO_END0;
            2'h1: lo_end = `PFP_LO_END1;
            2'h2: lo_end = `PFP_LO_END2;
            default: lo_end = `PFP_LO_END3;
        endcase
    end

    assign hi_en = ~cfg[`PFP_BIT_HDIS];
    assign lo_en = ~cfg[`PFP_BIT_LDIS];
    assign in_hi = hi_en && addr >= hi_start && addr <= `PFP_TOP_ADDR;
    assign in_lo = lo_en && addr >= `PFP_LOW_BASE && addr <= lo_end;

    // open mode protects windows, closed mode protects the rest
    assign prot = cfg[`PFP_BIT_OPEN] ? (in_hi | in_lo)
                                     : ~(in_hi | in_lo);

endmodule // pfp_range_check

// [hw/pfp_top.v]
`include "pfp_defs.vh"

module pfp_top (
    // clock and reset
    input wire ref_clk,
    input wire nrst,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // nonvolatile read port
    output reg nv_req,
    output reg [17:0] nv_addr,
    input wire nv_ack,
    input wire [7:0] nv_rdata,
    // flash command controller check port
    input wire cmd_valid,
    input wire [17:0] cmd_addr,
    output reg cmd_done_r,
    output reg cmd_prot_r,
    // status
    output reg cfg_ready_r
);

    reg [7:0] cfg_r;
    reg [7:0] cfg_nxt;
    reg last_prot_r;
    reg [17:0] chk_addr_r;
    wire ld_req;
    wire [17:0] ld_addr;
    wire ld_stb;
    wire [7:0] ld_data;
    wire ld_done;
    wire hit;
    wire sw_hit;
    wire wr_en;
    wire addr_ok;

    // ==========================================
    // decode helper
    function is_mapped;
        input [11:0] a;
        begin
            is_mapped = (a == `PFP_OFF_CONFIG) || (a == `PFP_OFF_STATUS)
                || (a == `PFP_OFF_CHECK);
        end
    endfunction

    // ==========================================
    // reset config fetch
    pfp_loader u_loader (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .nv_req_r(ld_req),
        .nv_addr_r(ld_addr),
        .nv_ack(nv_ack),
        .nv_rdata(nv_rdata),
        .load_stb_r(ld_stb),
        .load_data_r(ld_data),
        .done_r(ld_done)
    );

    // ==========================================
    // window decode for commands and for software probe
    pfp_range_check u_cmd_chk (
        .cfg(cfg_r),
        .addr(cmd_addr),
        .prot(hit)
    );

    pfp_range_check u_sw_chk (
        .cfg(cfg_r),
        .addr(chk_addr_r),
        .prot(sw_hit)
    );

    assign addr_ok = is_mapped(paddr);
    // writes held off until load completes so the nv value is not lost
    assign wr_en = psel && penable && pwrite && addr_ok && ld_done;

    // ==========================================
    // config next value with size write locks
    always @* begin
        cfg_nxt = cfg_r;
        if (ld_stb) begin
            cfg_nxt = ld_data;
        end else if (wr_en && paddr == `PFP_OFF_CONFIG) begin
            // free bits: open mode and both disables
            cfg_nxt = (cfg_r & ~`PFP_CFG_WMASK) | (pwdata[7:0] & `PFP_CFG_WMASK);
            if (cfg_r[`PFP_BIT_HDIS]) begin
                cfg_nxt[`PFP_HS_HI:`PFP_HS_LO] = pwdata[`PFP_HS_HI:`PFP_HS_LO];
            end
            if (cfg_r[`PFP_BIT_LDIS]) begin
                cfg_nxt[`PFP_LS_HI:`PFP_LS_LO] = pwdata[`PFP_LS_HI:`PFP_LS_LO];
            end
        end
    end

    // ==========================================
    // registers, apb answer and command check
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cfg_r <= `PFP_CFG_RESET;
            chk_addr_r <= 18'h00000;
            last_prot_r <= 1'b0;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            nv_req <= 1'b0;
            nv_addr <= 18'h00000;
            cmd_done_r <= 1'b0;
            cmd_prot_r <= 1'b0;
            cfg_ready_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            // drop the request at the ack edge so the far side never sees a second one
            nv_req <= ld_req && !nv_ack;
            nv_addr <= ld_addr;
            cfg_ready_r <= ld_done;
            // answer in setup+1, pulse pready one cycle
            pready <= psel && !penable;
            pslverr <= psel && !penable && !is_mapped(paddr);
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `PFP_OFF_CONFIG: prdata <= {24'h000000, cfg_r};
                    `PFP_OFF_STATUS: prdata <= {30'h00000000, last_prot_r, ld_done};
                    `PFP_OFF_CHECK: prdata <= {13'h0000, sw_hit, chk_addr_r};
                    default: prdata <= 32'h00000000;
                endcase
            end else begin
                // read data stands only alongside pready
                prdata <= 32'h00000000;
            end
            if (wr_en && paddr == `PFP_OFF_CHECK) begin
                chk_addr_r <= pwdata[17:0];
            end
            // commands refused until the config is loaded
            cmd_done_r <= cmd_valid;
            cmd_prot_r <= cmd_valid && (hit || !ld_done);
            if (cmd_valid) begin
                last_prot_r <= hit || !ld_done;
            end
        end
    end

endmodule // pfp_top

// [sim/pfp_monitor.sv]
module pfp_monitor (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // nonvolatile read port
    input wire logic nv_req,
    input wire logic [17:0] nv_addr,
    input wire logic nv_ack,
    // command check and status
    input wire logic cmd_valid,
    input wire logic cmd_done_r,
    input wire logic cmd_prot_r,
    input wire logic cfg_ready_r
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // ==========================================
    // load sequence
    property p_nv_addr; nv_req && $past(nv_req) |-> nv_addr == 18'h3FF0C; endproperty
    a_nv_addr: assert property (p_nv_addr) else $error("nv address wrong");
    property p_nv_hold; nv_req && !nv_ack |=> nv_req; endproperty
    a_nv_hold: assert property (p_nv_hold) else $error("nv request dropped");
    property p_load_done; nv_req && nv_ack |-> ##[1:4] cfg_ready_r; endproperty
    a_load_done: assert property (p_load_done) else $error("load not done");
    property p_unloaded; cmd_valid && nv_req |=> cmd_prot_r; endproperty
    a_unloaded: assert property (p_unloaded) else $error("early command allowed");
    property p_ready_holds; cfg_ready_r |=> cfg_ready_r; endproperty
    a_ready_holds: assert property (p_ready_holds) else $error("ready fell");
    // ==========================================
    // register bus and command port
    property p_apb_answer; psel && !penable |=> pready; endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("no pready");
    property p_idle_data; !pready |-> prdata == 32'h00000000 && !pslverr; endproperty
    a_idle_data: assert property (p_idle_data) else $error("stray read data");
    property p_cmd_answer; cmd_valid |=> cmd_done_r; endproperty
    a_cmd_answer: assert property (p_cmd_answer) else $error("no command answer");
    property p_cmd_quiet; !cmd_valid |=> !cmd_done_r; endproperty
    a_cmd_quiet: assert property (p_cmd_quiet) else $error("stray command answer");
endmodule // pfp_monitor

bind pfp_top pfp_monitor u_mon (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nv_req(nv_req), .nv_addr(nv_addr), .nv_ack(nv_ack), .cmd_valid(cmd_valid),
    .cmd_done_r(cmd_done_r), .cmd_prot_r(cmd_prot_r), .cfg_ready_r(cfg_ready_r));

// [sim/pfp_nvmem_model.sv]
module pfp_nvmem_model #(parameter logic [7:0] CFG_BYTE = 8'hFF, parameter int DELAY = 6) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // read port
    input wire logic nv_req,
    input wire logic [17:0] nv_addr,
    output logic nv_ack,
    output logic [7:0] nv_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // slow answer; data toggles outside the ack so a stale sample shows
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt <= 0;
            nv_ack <= 1'b0;
            nv_rdata <= 8'h00;
        end else if (nv_req && !nv_ack && cnt == DELAY) begin
            nv_ack <= 1'b1;
            nv_rdata <= (nv_addr == 18'h3FF0C) ? CFG_BYTE : 8'h00;
            cnt <= 0;
        end else begin
            nv_ack <= 1'b0;
            nv_rdata <= ~nv_rdata;
            cnt <= nv_req ? cnt + 1 : 0;
        end
    end
endmodule // pfp_nvmem_model

// [sim/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] NV_CFG = 8'hC9;
    logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, cmd_valid = 0, er, ld = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd, seed = 32'h7D2F2876;
    logic pready, pslverr, nv_req, nv_ack, cmd_done_r, cmd_prot_r, cfg_ready_r;
    logic [17:0] nv_addr, cmd_addr = 18'h00000;
    logic [7:0] nv_rdata, cfg, t;
    logic [17:0] corner [10] = '{18'h3F7FF, 18'h3F800, 18'h3EFFF, 18'h3E000, 18'h3BFFF,
        18'h383FF, 18'h38400, 18'h39FFF, 18'h38000, 18'h37FFF};
    int n_errors = 0, n_tests = 0;
    pfp_top dut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .nv_req(nv_req), .nv_addr(nv_addr), .nv_ack(nv_ack),
        .nv_rdata(nv_rdata), .cmd_valid(cmd_valid), .cmd_addr(cmd_addr),
        .cmd_done_r(cmd_done_r), .cmd_prot_r(cmd_prot_r), .cfg_ready_r(cfg_ready_r));
    pfp_nvmem_model #(.CFG_BYTE(NV_CFG), .DELAY(6)) u_nv (.ref_clk(ref_clk), .nrst(nrst),
        .nv_req(nv_req), .nv_addr(nv_addr), .nv_ack(nv_ack), .nv_rdata(nv_rdata));
    // ==========================================
    // helpers and models
    function logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // size bits follow the disable bit held before the write
    function logic [7:0] wr_model(input logic [7:0] c, input logic [7:0] w);
        logic [7:0] m;
        m = 8'hA4 | (c[5] ? 8'h18 : 8'h00) | (c[2] ? 8'h03 : 8'h00);
        return (c & ~m) | (w & m);
    endfunction
    function logic prot_model(input logic [7:0] c, input logic [17:0] a);
        logic [17:0] hs, le;
        logic hit;
        hs = 18'h3FFFF - ((18'h00800 << c[4:3]) - 18'h00001);
        le = 18'h38000 + (18'h00400 << c[1:0]) - 18'h00001;
        hit = (!c[5] && a >= hs) || (!c[2] && a >= 18'h38000 && a <= le);
        return c[7] ? hit : !hit;
    endfunction
    task check(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask
    // apb master: waits for pready, never assumes a latency
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) check("pready", 1, 0);
    endtask
    task cmd(input logic [17:0] a);
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_addr <= a;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        #1;
        check("cmd_done", 1, cmd_done_r);
        check("cmd_prot", ld ? prot_model(cfg, a) : 1'b1, cmd_prot_r);
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // ==========================================
    // clock, watchdog, main sequence
    initial forever #2.5 ref_clk = ~ref_clk;
    initial begin
        repeat (5000) @(posedge ref_clk);
        n_errors++;
        conclude;
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        apb(1'b1, 12'h000, 32'h00000000);
        repeat (3) cmd(18'h00000);
        for (int i = 0; i < 100 && cfg_ready_r !== 1'b1; i++) @(posedge ref_clk);
        ld = 1'b1;
        cfg = NV_CFG;
        apb(1'b0, 12'h000, 32'h00000000);
        check("config after load", {24'h000000, NV_CFG}, rd);
        $display("test load done");
        for (int k = 0; k < 24; k++) begin
            t = xs();
            if (k < 8) t = {k[2], t[6], k[1], t[4:3], k[0], t[1:0]};
            apb(1'b1, 12'h000, {24'h000000, t | 8'h24});
            cfg = wr_model(cfg, t | 8'h24);
            apb(1'b1, 12'h000, {24'h000000, t});
            cfg = wr_model(cfg, t);
            apb(1'b1, 12'h000, {24'h000000, t ^ 8'h1B});
            cfg = wr_model(cfg, t ^ 8'h1B);
            apb(1'b0, 12'h000, 32'h00000000);
            check("config", {24'h000000, cfg}, rd);
            foreach (corner[j]) cmd(corner[j]);
            rd = xs();
            cmd({3'b111, rd[14:0]});
        end
        $display("test windows done");
        foreach (corner[j]) begin
            apb(1'b1, 12'h008, {14'h0000, corner[j]});
            apb(1'b0, 12'h008, 32'h00000000);
            check("probe", {13'h0000, prot_model(cfg, corner[j]), corner[j]}, rd);
            cmd(corner[j] ^ 18'h00001);
            apb(1'b0, 12'h004, 32'h00000000);
            check("status", {30'h00000000, prot_model(cfg, corner[j] ^ 18'h00001), 1'b1}, rd);
        end
        $display("test probe done");
        apb(1'b0, 12'h010, 32'h00000000);
        check("unmapped error", 1, er);
        $display("test unmapped done");
        conclude;
    end
endmodule // testbench
